// ===== cmbt_asserts.sv
// port assertions for the can mode and bit timing block
`timescale 1ns/100ps
module cmbt_asserts (
    input logic                    mclk,
    input logic                    rst_b,
    input logic                    chip_wait_mode,
    input logic                    can_clock_enable,
    input logic                    rx_busy,
    input logic                    tx_buffers_empty,
    input logic                    sleep_ack,
    input logic                    soft_reset_active,
    input logic                    config_write_open,
    input logic                    bus_synced,
    input logic                    loopback_mode,
    input logic                    bus_transmit_pin,
    input logic                    core_tx_bit,
    input logic                    bus_receive_pin,
    input logic                    rx_to_core,
    input logic                    timer_port_pin,
    input logic                    timer_signal_out,
    input logic                    timer_input,
    input logic                    sample_point,
    input logic                    transmit_point
);
    // ----------------------------------------------------------
    // properties, all in the one mclk domain
    // ----------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_gate_wait: assert property (!chip_wait_mode |-> can_clock_enable)
        else $error("module clock gated outside wait");
    a_timer_src: assert property (timer_input == timer_port_pin
        || timer_input == timer_signal_out)
        else $error("timer input from no source");
    a_sleep_idle: assert property ($rose(sleep_ack) |->
        !$past(rx_busy) && $past(tx_buffers_empty))
        else $error("sleep entered while bus busy");
    // two edges allowed: the bit and the sync drop land on the same edge
    a_soft_desync: assert property (soft_reset_active |-> ##2 !bus_synced)
        else $error("sync kept in soft reset");
    a_cfg_gate: assert property (!config_write_open |=> $stable(loopback_mode))
        else $error("config changed outside soft reset");
    a_loop_tx: assert property (loopback_mode |-> bus_transmit_pin)
        else $error("transmit pin dominant in loop-back");
    a_loop_rx: assert property (rx_to_core ==
        (loopback_mode ? core_tx_bit : bus_receive_pin))
        else $error("receiver fed from wrong source");
    a_point_order: assert property (sample_point |-> !transmit_point)
        else $error("sample and transmit point coincide");
endmodule
bind cmbt_mode_timing cmbt_asserts u_chk (.mclk, .rst_b, .chip_wait_mode,
    .can_clock_enable, .rx_busy, .tx_buffers_empty, .sleep_ack, .soft_reset_active,
    .config_write_open, .bus_synced, .loopback_mode, .bus_transmit_pin, .core_tx_bit,
    .bus_receive_pin, .rx_to_core, .timer_port_pin, .timer_signal_out, .timer_input,
    .sample_point, .transmit_point);

// ===== cmbt_bus_node.sv
// model of the other nodes on the can bus
`timescale 1ns/100ps
module cmbt_bus_node (
    input  logic tx_pin,
    input  logic drive_dom,
    output logic rx_pin
);
    // wired-and bus, pulled recessive when nobody drives dominant
    assign rx_pin = tx_pin & !drive_dom;
endmodule

// ===== cmbt_mode_timing.sv
// can mode control, soft reset, sleep/wake and bit timing with ahb-lite registers
//
// Contract
// - stop-in-wait gates module clock in wait
// - read-only bit shows bus synchronization
// - timer link selects timer input source
// - sleep ack reads one while asleep
// - sleep entered only when bus idle
// - soft reset aborts traffic, drops sync
// - listed registers held at reset values
// - config registers writable only in soft reset
// - soft reset leaves error counters unchanged
// - resync after 11 recessive, bus-off 128 times
// - loop-back feeds tx to rx, pin recessive
// - loop-back ignores ack, own frames as remote; this block only routes tx to rx
// - wake on edge or filtered dominant pulse
// - clock select bit picks module clock
// - jump width is field plus one quanta
// - prescaler divides by field plus one
// - triple sampling uses majority of three
// - segment lengths are field plus one quanta
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/100ps
module cmbt_mode_timing #(
    parameter int unsigned IDLE_BITS   = cmbt_pkg::BUS_IDLE_BITS,
    parameter int unsigned OFF_OCCUR   = cmbt_pkg::BUS_OFF_OCCUR,
    parameter int unsigned WAKE_CYCLES = cmbt_pkg::WAKE_FILTER_CYC
) (
    input  wire logic                    mclk,
    input  wire logic                    rst_b,
    input  wire logic                    clk_en,
    input  wire cmbt_pkg::cmbt_ahb_req_s ahb_req,
    output cmbt_pkg::cmbt_ahb_rsp_s      ahb_rsp,
    input  wire logic                    chip_wait_mode,
    input  wire logic                    bus_receive_pin,
    output logic                         bus_transmit_pin,
    input  wire logic                    core_tx_bit,
    input  wire logic                    rx_busy,
    input  wire logic                    tx_buffers_empty,
    input  wire logic                    bus_off,
    input  wire logic                    timer_port_pin,
    input  wire logic                    timer_signal_out,
    output logic                         timer_input,
    output logic                         can_clock_enable,
    output logic                         module_clock_select,
    output logic                         soft_reset_active,
    output logic                         config_write_open,
    output logic                         loopback_mode,
    output logic                         rx_to_core,
    output logic                         bus_synced,
    output logic                         sleep_ack,
    output logic                         wake_event,
    output logic                         bus_off_recovered,
    output logic                         sample_point,
    output logic                         sampled_bit,
    output logic                         transmit_point
);

    // --------------------------------------------------------------
    // elaboration checks
    // --------------------------------------------------------------
    if (IDLE_BITS < 1 || IDLE_BITS >= (1 << cmbt_pkg::REC_CNT_W)) begin : g_chk_idle
        $error("IDLE_BITS does not fit the recessive counter");
    end
    if (OFF_OCCUR < 1 || OFF_OCCUR >= (1 << cmbt_pkg::OCC_CNT_W)) begin : g_chk_occ
        $error("OFF_OCCUR does not fit the occurrence counter");
    end
    if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (1 << cmbt_pkg::WAKE_CNT_W)) begin : g_chk_wake
        $error("WAKE_CYCLES does not fit the wake filter counter");
    end

    localparam logic [cmbt_pkg::REC_CNT_W-1:0]  IDLE_MAX = IDLE_BITS[cmbt_pkg::REC_CNT_W-1:0];
    localparam logic [cmbt_pkg::OCC_CNT_W-1:0]  OCC_MAX  = OFF_OCCUR[cmbt_pkg::OCC_CNT_W-1:0];
    localparam logic [cmbt_pkg::WAKE_CNT_W-1:0] WAKE_MAX =
        WAKE_CYCLES[cmbt_pkg::WAKE_CNT_W-1:0];

    cmbt_pkg::cmbt_state_s q;
    cmbt_pkg::cmbt_state_s d;

    // --------------------------------------------------------------
    // field views of the stored registers
    // --------------------------------------------------------------
    logic [1:0] resync_jump_width;
    logic [5:0] quantum_prescaler;
    logic [2:0] time_segment_two;
    logic [3:0] time_segment_one;
    logic       triple;
    logic [4:0] sjw_len;
    logic [4:0] seg1_len;
    logic [4:0] seg2_len;

    // jump width and segment fields count field plus one quanta
    assign resync_jump_width      = q.btr0[cmbt_pkg::BTR0_SJW_LSB +: 2];
    assign quantum_prescaler      = q.btr0[cmbt_pkg::BTR0_BRP_LSB +: 6];
    assign time_segment_two    = q.btr1[cmbt_pkg::BTR1_TIME_SEGMENT_TWO_LSB +: 3];
    assign time_segment_one    = q.btr1[cmbt_pkg::BTR1_TIME_SEGMENT_ONE_LSB +: 4];
    assign triple   = q.btr1[cmbt_pkg::BTR1_TRIPLE_SAMPLING];
    assign sjw_len  = {3'b000, resync_jump_width} + 5'd1;
    assign seg1_len = {1'b0, time_segment_one} + 5'd1;
    assign seg2_len = {2'b00, time_segment_two} + 5'd1;

    // --------------------------------------------------------------
    // pin and clock steering
    // --------------------------------------------------------------
    logic rx_bit;
    logic bit_run;
    logic tq_tick;

    // clock stops only when both wait mode and the stop bit are set
    assign can_clock_enable    = ~(q.stop_in_wait & chip_wait_mode);
    assign timer_input         = q.timer_link_enable ? timer_signal_out
                                                     : timer_port_pin;
    assign module_clock_select = q.cfg[cmbt_pkg::CFG_CLKSEL];
    assign loopback_mode       = q.cfg[cmbt_pkg::CFG_LOOP];
    // loop-back: transmitter drives receiver, pin parked recessive
    assign rx_bit              = loopback_mode ? core_tx_bit : bus_receive_pin;
    assign bus_transmit_pin    = loopback_mode ? 1'b1 : core_tx_bit;
    assign rx_to_core          = rx_bit;
    assign soft_reset_active   = q.soft_reset_bit;
    assign config_write_open   = q.soft_reset_bit;
    assign bus_synced          = q.bus_synced;
    assign sleep_ack           = q.sleep_ack;
    assign wake_event          = q.wake_pulse;
    assign bus_off_recovered   = q.recovered;
    assign sample_point        = q.sample_pulse;
    assign sampled_bit         = q.sampled;
    assign transmit_point      = q.tx_point;

    // bit timing runs only with a live module clock, out of soft reset and sleep
    assign bit_run = can_clock_enable & ~q.soft_reset_bit & ~q.sleep_ack;
    assign tq_tick = bit_run & (q.tq_div == quantum_prescaler);

    // --------------------------------------------------------------
    // ahb-lite slave; zero wait states, frozen with the clock enable
    // --------------------------------------------------------------
    logic        addr_take;
    logic [11:0] addr_idx;
    logic [7:0]  main_view;
    logic [7:0]  wbyte;

    assign addr_take = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
    assign addr_idx  = ahb_req.haddr[13:2];
    assign wbyte     = ahb_req.hwdata[7:0];
    // hready drops while frozen so no transfer is lost
    assign ahb_rsp.hreadyout = clk_en;
    assign ahb_rsp.hresp     = 1'b0;
    assign ahb_rsp.hrdata    = q.rdata;

    // main register as software reads it; upper bits read zero
    always_comb begin
        main_view                          = 8'h00;
        main_view[cmbt_pkg::MAIN_STOP_WAIT] = q.stop_in_wait;
        main_view[cmbt_pkg::MAIN_SYNCED]    = q.bus_synced;
        main_view[cmbt_pkg::MAIN_TLINK]     = q.timer_link_enable;
        main_view[cmbt_pkg::MAIN_SLP_ACK]   = q.sleep_ack;
        main_view[cmbt_pkg::MAIN_SLP_REQ]   = q.sleep_request;
        main_view[cmbt_pkg::MAIN_SOFT]      = q.soft_reset_bit;
    end

    // --------------------------------------------------------------
    // next-state logic for the whole block
    // --------------------------------------------------------------
    always_comb begin
        logic edge_fall;
        logic maj;
        edge_fall = 1'b0;
        maj       = 1'b0;
        d         = q;
        d.sample_pulse = 1'b0;
        d.tx_point     = 1'b0;
        d.recovered    = 1'b0;
        d.wake_pulse   = 1'b0;

        // address phase: latch index and capture read data
        d.dph_write = 1'b0;
        if (addr_take) begin
            d.dph_write = ahb_req.hwrite;
            d.dph_idx   = addr_idx;
            d.rdata     = 32'h0000_0000;
            if (!ahb_req.hwrite && ahb_req.haddr[1:0] == 2'b00) begin
                case (addr_idx)
                    cmbt_pkg::IDX_MAIN:   d.rdata[7:0] = main_view;
                    cmbt_pkg::IDX_CONFIG: d.rdata[7:0] = q.cfg;
                    cmbt_pkg::IDX_BTR0:   d.rdata[7:0] = q.btr0;
                    cmbt_pkg::IDX_BTR1:   d.rdata[7:0] = q.btr1;
                    default:              d.rdata      = 32'h0000_0000;
                endcase
            end
        end

        // data phase: apply the write
        if (q.dph_write) begin
            case (q.dph_idx)
                cmbt_pkg::IDX_MAIN: begin
                    if (q.soft_reset_bit) begin
                        // only the soft reset bit moves; the rest stays at reset
                        d.soft_reset_bit = wbyte[cmbt_pkg::MAIN_SOFT];
                    end else begin
                        d.stop_in_wait      = wbyte[cmbt_pkg::MAIN_STOP_WAIT];
                        d.timer_link_enable = wbyte[cmbt_pkg::MAIN_TLINK];
                        d.sleep_request     = wbyte[cmbt_pkg::MAIN_SLP_REQ];
                        d.soft_reset_bit    = wbyte[cmbt_pkg::MAIN_SOFT];
                    end
                end
                cmbt_pkg::IDX_CONFIG: begin
                    if (q.soft_reset_bit) begin
                        d.cfg = wbyte & 8'h07;
                    end
                end
                cmbt_pkg::IDX_BTR0: begin
                    if (q.soft_reset_bit) begin
                        d.btr0 = wbyte;
                    end
                end
                cmbt_pkg::IDX_BTR1: begin
                    if (q.soft_reset_bit) begin
                        d.btr1 = wbyte;
                    end
                end
                default: begin
                end
            endcase
        end

        // quantum prescaler
        if (bit_run) begin
            d.tq_div = tq_tick ? 6'd0 : q.tq_div + 6'd1;
        end

        // bit timing: sync quantum, segment one, sample, segment two
        if (tq_tick) begin
            edge_fall = q.rx_prev & ~rx_bit;
            d.rx_prev = rx_bit;
            case (q.phase)
                cmbt_pkg::CMBT_SYNC: begin
                    d.phase   = cmbt_pkg::CMBT_SEG1;
                    d.seg_cnt = 5'd0;
                    d.seg_len = seg1_len;
                end
                cmbt_pkg::CMBT_SEG1: begin
                    d.hist    = {q.hist[0], rx_bit};
                    d.seg_cnt = q.seg_cnt + 5'd1;
                    // late edge: stretch segment one once, by jump width at most
                    if (edge_fall && q.seg_len == seg1_len) begin
                        d.seg_len = q.seg_len + ((q.seg_cnt + 5'd1 < sjw_len) ?
                                                 q.seg_cnt + 5'd1 : sjw_len);
                    end else if (q.seg_cnt + 5'd1 >= q.seg_len) begin
                        // sample point at the end of segment one
                        maj = (q.hist[1] & q.hist[0]) | (q.hist[1] & rx_bit)
                            | (q.hist[0] & rx_bit);
                        d.sampled      = triple ? maj : rx_bit;
                        d.sample_pulse = 1'b1;
                        d.phase        = cmbt_pkg::CMBT_SEG2;
                        d.seg_cnt      = 5'd0;
                        d.seg_len      = seg2_len;
                    end
                end
                cmbt_pkg::CMBT_SEG2: begin
                    d.seg_cnt = q.seg_cnt + 5'd1;
                    if (edge_fall) begin
                        // early edge: shorten segment two by jump width at most
                        if (q.seg_len - q.seg_cnt <= sjw_len) begin
                            d.phase   = cmbt_pkg::CMBT_SEG1;
                            d.seg_cnt = 5'd0;
                            d.seg_len = seg1_len;
                            d.tx_point = 1'b1;
                        end else begin
                            d.seg_len = q.seg_len - sjw_len;
                        end
                    end else if (q.seg_cnt + 5'd1 >= q.seg_len) begin
                        d.phase    = cmbt_pkg::CMBT_SYNC;
                        d.tx_point = 1'b1;
                    end
                end
                default: begin
                    d.phase = cmbt_pkg::CMBT_SYNC;
                end
            endcase
        end

        // bus synchronization by counting recessive samples
        if (q.sample_pulse && !q.bus_synced) begin
            if (!q.sampled) begin
                d.rec_cnt = '0;
            end else if (q.rec_cnt + 1'b1 >= IDLE_MAX) begin
                d.rec_cnt = '0;
                if (!bus_off) begin
                    d.bus_synced = 1'b1;
                end else if (q.occ_cnt + 1'b1 >= OCC_MAX) begin
                    d.occ_cnt    = '0;
                    d.bus_synced = 1'b1;
                    d.recovered  = 1'b1;
                end else begin
                    d.occ_cnt = q.occ_cnt + 1'b1;
                end
            end else begin
                d.rec_cnt = q.rec_cnt + 1'b1;
            end
        end

        // sleep handshake: enter only with the bus idle
        if (!q.sleep_request) begin
            d.sleep_ack = 1'b0;
        end else if (!q.sleep_ack && !rx_busy && tx_buffers_empty) begin
            d.sleep_ack = 1'b1;
        end

        // wake detection; runs on the plain clock so a gated module still wakes
        d.wake_prev = rx_bit;
        if (q.sleep_ack) begin
            if (q.cfg[cmbt_pkg::CFG_WAKE_FILT]) begin
                // filtered: dominant must last the whole filter time
                if (rx_bit) begin
                    d.wake_cnt = '0;
                end else if (q.wake_cnt + 1'b1 >= WAKE_MAX) begin
                    d.wake_cnt   = '0;
                    d.wake_pulse = 1'b1;
                end else begin
                    d.wake_cnt = q.wake_cnt + 1'b1;
                end
            end else if (q.wake_prev && !rx_bit) begin
                d.wake_pulse = 1'b1;
            end
            if (d.wake_pulse) begin
                d.sleep_ack     = 1'b0;
                d.sleep_request = 1'b0;
            end
        end else begin
            d.wake_cnt = '0;
        end

        // soft reset holds main control and timing state at reset;
        // error counters live outside and are never touched here
        if (d.soft_reset_bit) begin
            d.stop_in_wait      = cmbt_pkg::MAIN_RST[cmbt_pkg::MAIN_STOP_WAIT];
            d.timer_link_enable = cmbt_pkg::MAIN_RST[cmbt_pkg::MAIN_TLINK];
            d.sleep_request     = cmbt_pkg::MAIN_RST[cmbt_pkg::MAIN_SLP_REQ];
            d.sleep_ack         = cmbt_pkg::MAIN_RST[cmbt_pkg::MAIN_SLP_ACK];
            d.bus_synced        = cmbt_pkg::MAIN_RST[cmbt_pkg::MAIN_SYNCED];
            d.tq_div            = 6'd0;
            d.phase             = cmbt_pkg::CMBT_SYNC;
            d.seg_cnt           = 5'd0;
            d.seg_len           = 5'd0;
            d.hist              = 2'b11;
            d.rx_prev           = 1'b1;
            d.rec_cnt           = '0;
            d.occ_cnt           = '0;
            d.wake_cnt          = '0;
            d.sample_pulse      = 1'b0;
            d.tx_point          = 1'b0;
        end
    end

    // --------------------------------------------------------------
    // state register; clock enable low freezes everything
    // --------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            q                   <= '0;
            q.stop_in_wait      <= cmbt_pkg::MAIN_RST[cmbt_pkg::MAIN_STOP_WAIT];
            q.soft_reset_bit    <= cmbt_pkg::MAIN_RST[cmbt_pkg::MAIN_SOFT];
            q.cfg               <= cmbt_pkg::CFG_RST;
            q.btr0              <= cmbt_pkg::BTR0_RST;
            q.btr1              <= cmbt_pkg::BTR1_RST;
            q.phase             <= cmbt_pkg::CMBT_SYNC;
            q.hist              <= 2'b11;
            q.rx_prev           <= 1'b1;
            q.wake_prev         <= 1'b1;
        end else if (clk_en) begin
            q <= d;
        end
    end

endmodule

// ===== cmbt_pkg.sv
// package for the can mode and bit timing control block
package cmbt_pkg;

    // --------------------------------------------------------------
    // clock and timing
    // --------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned WAKE_FILTER_NS = 2000;
    // least time, so round up to whole cycles
    localparam int unsigned WAKE_FILTER_CYC =
        (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAKE_CNT_W     = 16;
    localparam int unsigned BUS_IDLE_BITS  = 11;
    localparam int unsigned BUS_OFF_OCCUR  = 128;
    localparam int unsigned REC_CNT_W      = 4;
    localparam int unsigned OCC_CNT_W      = 8;

    // --------------------------------------------------------------
    // register indexes; byte address is four times the index
    // --------------------------------------------------------------
    localparam logic [11:0] IDX_MAIN   = 12'h100;
    localparam logic [11:0] IDX_CONFIG = 12'h101;
    localparam logic [11:0] IDX_BTR0   = 12'h102;
    localparam logic [11:0] IDX_BTR1   = 12'h103;

    // --------------------------------------------------------------
    // field positions and reset values
    // --------------------------------------------------------------
    localparam int unsigned MAIN_STOP_WAIT = 5;
    localparam int unsigned MAIN_SYNCED    = 4;
    localparam int unsigned MAIN_TLINK     = 3;
    localparam int unsigned MAIN_SLP_ACK   = 2;
    localparam int unsigned MAIN_SLP_REQ   = 1;
    localparam int unsigned MAIN_SOFT      = 0;
    localparam logic [7:0]  MAIN_RST       = 8'h21;
    localparam int unsigned CFG_LOOP       = 2;
    localparam int unsigned CFG_WAKE_FILT  = 1;
    localparam int unsigned CFG_CLKSEL     = 0;
    localparam logic [7:0]  CFG_RST        = 8'h00;
    localparam int unsigned BTR0_SJW_LSB   = 6;
    localparam int unsigned BTR0_BRP_LSB   = 0;
    localparam logic [7:0]  BTR0_RST       = 8'h00;
    localparam int unsigned BTR1_TRIPLE_SAMPLING      = 7;
    localparam int unsigned BTR1_TIME_SEGMENT_TWO_LSB = 4;
    localparam int unsigned BTR1_TIME_SEGMENT_ONE_LSB = 0;
    localparam logic [7:0]  BTR1_RST       = 8'h00;

    // --------------------------------------------------------------
    // types
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        CMBT_SYNC = 2'b00,
        CMBT_SEG1 = 2'b01,
        CMBT_SEG2 = 2'b10
    } cmbt_phase_e;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } cmbt_ahb_req_s;

    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } cmbt_ahb_rsp_s;

    typedef struct packed {
        logic                  stop_in_wait;
        logic                  timer_link_enable;
        logic                  sleep_request;
        logic                  soft_reset_bit;
        logic                  bus_synced;
        logic                  sleep_ack;
        logic [7:0]            cfg;
        logic [7:0]            btr0;
        logic [7:0]            btr1;
        logic                  dph_write;
        logic [11:0]           dph_idx;
        logic [31:0]           rdata;
        logic [5:0]            tq_div;
        cmbt_phase_e           phase;
        logic [4:0]            seg_cnt;
        logic [4:0]            seg_len;
        logic [1:0]            hist;
        logic                  rx_prev;
        logic                  sampled;
        logic                  sample_pulse;
        logic                  tx_point;
        logic [REC_CNT_W-1:0]  rec_cnt;
        logic [OCC_CNT_W-1:0]  occ_cnt;
        logic                  recovered;
        logic                  wake_prev;
        logic [WAKE_CNT_W-1:0] wake_cnt;
        logic                  wake_pulse;
    } cmbt_state_s;

endpackage

// ===== tb_top.sv
// self-checking bench for the can mode and bit timing block
`timescale 1ns/100ps
module tb_top;
    // ----------------------------------------------------------
    // stimulus, observed outputs and counters
    // ----------------------------------------------------------
    logic mclk = 0, rst_b = 0, cw = 0, ctx = 1, rxb = 0, dom = 0, bof = 0;
    logic rx_pin, tx_pin, tmr, cke, syn, slp, wev, tpt, rxc, smp, mcs, bor;
    cmbt_pkg::cmbt_ahb_req_s req = '0;
    cmbt_pkg::cmbt_ahb_rsp_s rsp;
    int num_errors = 0, comparisons = 0, cyc = 0, k;
    always #5 mclk = ~mclk;
    cmbt_bus_node node (.tx_pin(tx_pin), .drive_dom(dom), .rx_pin(rx_pin));
    cmbt_mode_timing dut (.mclk(mclk), .rst_b(rst_b), .clk_en(1'b1), .ahb_req(req),
        .ahb_rsp(rsp), .chip_wait_mode(cw), .bus_receive_pin(rx_pin),
        .bus_transmit_pin(tx_pin), .core_tx_bit(ctx), .rx_busy(rxb),
        .tx_buffers_empty(1'b1), .bus_off(bof), .timer_port_pin(1'b0),
        .timer_signal_out(1'b1), .timer_input(tmr), .can_clock_enable(cke),
        .module_clock_select(mcs), .soft_reset_active(), .config_write_open(),
        .loopback_mode(), .rx_to_core(rxc), .bus_synced(syn), .sleep_ack(slp),
        .wake_event(wev), .bus_off_recovered(bor), .sample_point(), .sampled_bit(smp),
        .transmit_point(tpt));
    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // one ahb-lite single word; d is write data or expected read
    task automatic acc(logic w, logic [11:0] i, logic [7:0] d);
        @(posedge mclk);
        req <= '{1'b1, {18'h0, i, 2'b00}, 2'b10, w, 3'b010, 32'h0, 1'b1};
        do @(posedge mclk); while (rsp.hreadyout !== 1'b1);
        req <= '{1'b0, 32'h0, 2'b00, 1'b0, 3'b010, {24'h0, d}, 1'b1};
        do @(posedge mclk); while (rsp.hreadyout !== 1'b1);
        if (!w) chk("hrdata", {24'h0, d}, rsp.hrdata);
    endtask
    // hang guard, bus-off recovery alone needs about 17000 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            report_and_stop;
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1;
        cw <= 1;
        @(negedge mclk) chk("clock_enable", 0, cke);
        @(posedge mclk) cw <= 0;
        acc(0, cmbt_pkg::IDX_MAIN, 8'h21);
        acc(0, 12'h104, 8'h00);
        acc(1, cmbt_pkg::IDX_BTR0, 8'h01);
        acc(1, cmbt_pkg::IDX_BTR1, 8'h12);
        acc(0, cmbt_pkg::IDX_BTR1, 8'h12);
        acc(1, cmbt_pkg::IDX_MAIN, 8'h20);
        // eleven bits of 12 cycles cannot complete in 110 cycles
        repeat (110) @(negedge mclk);
        chk("early_sync", 0, syn);
        for (k = 0; k < 100 && syn !== 1'b1; k++) @(negedge mclk);
        chk("bus_synced", 1, syn);
        chk("sampled_bit", 1, smp);
        for (k = 0; k < 50 && tpt !== 1'b1; k++) @(negedge mclk);
        for (k = 1; k < 50; k++) begin
            @(negedge mclk);
            if (tpt === 1'b1) break;
        end
        chk("bit_cycles", 12, k);
        acc(1, cmbt_pkg::IDX_MAIN, 8'h28);
        acc(0, cmbt_pkg::IDX_MAIN, 8'h38);
        chk("timer_input", 1, tmr);
        acc(1, cmbt_pkg::IDX_CONFIG, 8'h04);
        acc(0, cmbt_pkg::IDX_CONFIG, 8'h00);
        @(posedge mclk) rxb <= 1;
        acc(1, cmbt_pkg::IDX_MAIN, 8'h2A);
        repeat (5) @(negedge mclk);
        chk("sleep_busy", 0, slp);
        @(posedge mclk) rxb <= 0;
        repeat (3) @(negedge mclk);
        chk("sleep_ack", 1, slp);
        @(posedge mclk) dom <= 1;
        for (k = 0; k < 10 && wev !== 1'b1; k++) @(negedge mclk);
        chk("wake_event", 1, wev);
        @(negedge mclk) chk("awake", 0, slp);
        @(posedge mclk) dom <= 0;
        acc(1, cmbt_pkg::IDX_MAIN, 8'h01);
        acc(0, cmbt_pkg::IDX_MAIN, 8'h21);
        chk("sync_lost", 0, syn);
        chk("timer_port", 0, tmr);
        acc(1, cmbt_pkg::IDX_CONFIG, 8'h05);
        acc(0, cmbt_pkg::IDX_CONFIG, 8'h05);
        chk("clock_select", 1, mcs);
        @(posedge mclk) ctx <= 0;
        @(negedge mclk) chk("tx_pin", 1, tx_pin);
        chk("rx_to_core", 0, rxc);
        // bus-off: 128 runs of eleven recessive bits before resync
        @(posedge mclk) bof <= 1;
        ctx <= 1;
        acc(1, cmbt_pkg::IDX_MAIN, 8'h00);
        for (k = 0; k < 20000 && bor !== 1'b1; k++) @(negedge mclk);
        chk("bus_off_recovered", 1, bor);
        chk("resynced", 1, syn);
        report_and_stop;
    end
endmodule
